/* File: inc/ttcu_pkg.sv */
// constants shared by the triple timer/counter unit
// assumes a single clock domain and word-aligned AHB-Lite register access
package ttcu_pkg;

	// ------------------------------------------------------------
	// machine cycle
	// ------------------------------------------------------------
	localparam int unsigned MC_LONG  = 12;
	localparam int unsigned MC_SHORT = 6;
	localparam int unsigned PH_C3    = 2;
	localparam int unsigned PH_C4    = 3;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_TMODE  = 8'h00;
	localparam logic [7:0] OFS_TCTRL  = 8'h04;
	localparam logic [7:0] OFS_TL0    = 8'h08;
	localparam logic [7:0] OFS_TH0    = 8'h0C;
	localparam logic [7:0] OFS_TL1    = 8'h10;
	localparam logic [7:0] OFS_TH1    = 8'h14;
	localparam logic [7:0] OFS_T2CTRL = 8'h18;
	localparam logic [7:0] OFS_T2MODE = 8'h1C;
	localparam logic [7:0] OFS_CAPL   = 8'h20;
	localparam logic [7:0] OFS_CAPH   = 8'h24;
	localparam logic [7:0] OFS_TL2    = 8'h28;
	localparam logic [7:0] OFS_TH2    = 8'h2C;
	localparam logic [7:0] OFS_CFG    = 8'h30;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned TM_M0   = 0;
	localparam int unsigned TM_M1   = 1;
	localparam int unsigned TM_CT   = 2;
	localparam int unsigned TM_GATE = 3;
	localparam int unsigned TM_T1   = 4;
	localparam int unsigned TC_TR0  = 4;
	localparam int unsigned TC_TF0  = 5;
	localparam int unsigned TC_TR1  = 6;
	localparam int unsigned TC_TF1  = 7;
	localparam int unsigned T2_CPRL = 0;
	localparam int unsigned T2_CT   = 1;
	localparam int unsigned T2_TR   = 2;
	localparam int unsigned T2_EXEN = 3;
	localparam int unsigned T2_EXF  = 6;
	localparam int unsigned T2_TF   = 7;
	localparam int unsigned T2M_DOWN_COUNT_ENABLE = 0;
	localparam int unsigned CFG_SIXT = 0;

	// ------------------------------------------------------------
	// modes, edge inputs, reset values, bus
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_13    = 2'h0;
	localparam logic [1:0] MODE_16    = 2'h1;
	localparam logic [1:0] MODE_RLD   = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam int unsigned EDGE_T0   = 0;
	localparam int unsigned EDGE_T1   = 1;
	localparam int unsigned EDGE_T2   = 2;
	localparam int unsigned EDGE_TRIG = 3;
	localparam int unsigned NUM_EDGE  = 4;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [2:0] SIZE_WORD  = 3'h2;
	localparam logic       RESP_OKAY  = 1'b0;

endpackage

/* File: inc/ttcu_mc_if.sv */
// machine-cycle phase strobes passed from the time base to its users
// assumes both strobes are single-cycle pulses on the one system clock
`timescale 1ns/10ps
`default_nettype none

interface ttcu_mc_if;
	logic mcSample;
	logic mcUpdate;
	modport src (output mcSample, output mcUpdate);
	modport snk (input mcSample, input mcUpdate);
endinterface

`default_nettype wire

/* File: rtl/ttcu_timebase.sv */
// machine-cycle generator: 12 or 6 clocks per machine cycle
// assumes sixT may change at any time; the cycle wraps at once only if the count is already at or past its new last phase
`timescale 1ns/10ps
`default_nettype none

module ttcu_timebase
	import ttcu_pkg::*;
#(
	parameter int unsigned LONG_LEN  = MC_LONG,
	parameter int unsigned SHORT_LEN = MC_SHORT
) (
	input  wire logic clk,   // system clock
	input  wire logic srst,  // synchronous reset
	input  wire logic sixT,  // short machine cycle select
	ttcu_mc_if.src    mc     // phase strobes
);
	localparam int unsigned CW = $clog2(LONG_LEN);

	generate
		if (SHORT_LEN <= PH_C4 || LONG_LEN < SHORT_LEN) begin : g_bad
			$error("ttcu_timebase: cycle lengths cannot hold both phases");
		end
	endgenerate

	logic [CW-1:0] cntQ;
	logic [CW-1:0] lastPh;

	assign lastPh = sixT ? CW'(SHORT_LEN - 1) : CW'(LONG_LEN - 1);

	always_ff @(posedge clk) begin
		if (srst || cntQ >= lastPh) begin
			cntQ <= '0;
		end else begin
			cntQ <= cntQ + CW'(1);
		end
	end

	// update comes before sample, so an edge seen now counts next cycle
	assign mc.mcUpdate = (cntQ == CW'(PH_C3));
	assign mc.mcSample = (cntQ == CW'(PH_C4));

endmodule

`default_nettype wire

/* File: rtl/ttcu_edge_det.sv */
// falling-edge recogniser for pins sampled once per machine cycle
// assumes pins are synchronous to clk; result holds one machine cycle
`timescale 1ns/10ps
`default_nettype none

module ttcu_edge_det #(
	parameter int unsigned W = 4
) (
	input  wire logic         clk,    // system clock
	input  wire logic         srst,   // synchronous reset
	input  wire logic [W-1:0] pins,   // sampled inputs
	ttcu_mc_if.snk            mc,     // phase strobes
	output logic      [W-1:0] falls   // high-then-low seen
);
	generate
		if (W < 1) begin : g_bad
			$error("ttcu_edge_det: width must be at least one");
		end
		for (genvar i = 0; i < W; i++) begin : g_pin
			logic lastQ;
			always_ff @(posedge clk) begin
				if (srst) begin
					lastQ    <= 1'b0;
					falls[i] <= 1'b0;
				end else if (mc.mcSample) begin
					lastQ    <= pins[i];
					falls[i] <= lastQ & ~pins[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* File: rtl/ttcu_top.sv */
// three-timer counter unit with an AHB-Lite register slave
// assumes one clock, a single AHB-Lite master and word-wide accesses
//
// What this block does
// - count pins sampled once per machine cycle; high then low counts one
// - counts change only at update phase, one cycle after the edge
// - function select is mode bit 2 for timer 0, bit 6 for timer 1
// - machine cycle is 12 or 6 clocks, by configuration
// - timer function counts at clock/12 by default
// - mode 0 is 13 bits: high byte plus low five of low byte
// - timers 0/1 count when run set and gate clear or pin high
// - mode 0 rollover from 1FFF sets the overflow flag
// - mode 1 uses sixteen bits, flag on rollover from FFFF
// - mode 2 low byte reloads from high byte on overflow, sets flag
// - timer 1 in mode 3 holds its count
// - timer 0 mode 3 low byte uses all timer 0 controls
// - timer 0 mode 3 high byte counts cycles, uses timer 1 run and flag
// - then timer 1 runs without run bit or flag, gated by own mode 3
// - timer 2 counts pin or cycles by clock select, while run bit set
// - timer 2 capture mode counts up, flag on rollover from FFFF
// - capture mode trigger edge copies count and sets trigger flag
// - reload mode counts up, reloads from capture bytes, sets flag
// - reload mode trigger edge also reloads and sets trigger flag
// - timer 0/1 overflow flags clear when the core vectors to them
// - timer 2 flags clear only by software
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module ttcu_top
	import ttcu_pkg::*;
(
	input  wire logic        clk,                       // system clock
	input  wire logic        srst,                      // synchronous reset
	input  wire logic        hsel,                      // slave select
	input  wire logic [31:0] haddr,                     // byte address
	input  wire logic [1:0]  htrans,                    // transfer type
	input  wire logic        hwrite,                    // write when high
	input  wire logic [2:0]  hsize,                     // transfer size
	input  wire logic [31:0] hwdata,                    // write data
	input  wire logic        hready,                    // bus ready
	output logic             hreadyout,                 // slave ready
	output logic [31:0]      hrdata,                    // read data
	output logic             hresp,                     // always okay
	input  wire logic        countPinZero,              // timer 0 count pin
	input  wire logic        countPinOne,               // timer 1 count pin
	input  wire logic        countPinTwo,               // timer 2 count pin
	input  wire logic        triggerPin,                // timer 2 trigger pin
	input  wire logic        externalInterruptPinZero,  // timer 0 gate pin
	input  wire logic        externalInterruptPinOne,   // timer 1 gate pin
	input  wire logic        vectorAckZero,             // core vectors to timer 0
	input  wire logic        vectorAckOne,              // core vectors to timer 1
	output logic             timerZeroOverflowFlag,     // timer 0 request
	output logic             timerOneOverflowFlag,      // timer 1 request
	output logic             timerTwoOverflowFlag,      // timer 2 request
	output logic             externalTriggerFlag        // trigger request
);
	// ------------------------------------------------------------
	// machine cycle and pin edges
	// ------------------------------------------------------------
	ttcu_mc_if mcBus ();

	logic                sixTModeQ;
	logic [NUM_EDGE-1:0] edgePins;
	logic [NUM_EDGE-1:0] falls;

	ttcu_timebase u_timebase (
		.clk  (clk),
		.srst (srst),
		.sixT (sixTModeQ),
		.mc   (mcBus)
	);

	assign edgePins[EDGE_T0]   = countPinZero;
	assign edgePins[EDGE_T1]   = countPinOne;
	assign edgePins[EDGE_T2]   = countPinTwo;
	assign edgePins[EDGE_TRIG] = triggerPin;

	ttcu_edge_det #(
		.W (NUM_EDGE)
	) u_edges (
		.clk   (clk),
		.srst  (srst),
		.pins  (edgePins),
		.mc    (mcBus),
		.falls (falls)
	);

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic       wrPendQ;
	logic       rdPendQ;
	logic       sizeOkQ;
	logic [7:0] addrQ;
	logic [7:0] wByte;
	logic [7:0] rdByte;
	logic       accept;

	assign accept    = hsel & hready & htrans[1];
	assign wByte     = hwdata[7:0];
	assign hreadyout = ~rdPendQ;
	assign hresp     = RESP_OKAY;

	function automatic logic wrHit(input logic [7:0] off);
		return wrPendQ & sizeOkQ & (addrQ == off);
	endfunction

	always_ff @(posedge clk) begin
		if (srst) begin
			wrPendQ <= 1'b0;
			rdPendQ <= 1'b0;
			sizeOkQ <= 1'b0;
			addrQ   <= RST_BYTE;
		end else begin
			wrPendQ <= accept & hwrite;
			rdPendQ <= accept & ~hwrite;
			if (accept) begin
				addrQ   <= haddr[7:0];
				sizeOkQ <= (hsize == SIZE_WORD);
			end
		end
	end

	// one wait state on reads so a write just before is already seen
	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata <= '0;
		end else if (rdPendQ) begin
			hrdata <= {24'h000000, rdByte};
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic [7:0] timerModeRegister;
	logic       tr0Q;
	logic       tr1Q;
	logic       tr2Q;
	logic       ct2Q;
	logic       cpRlQ;
	logic       exenQ;
	logic       downCountEnableQ;

	always_ff @(posedge clk) begin
		if (srst) begin
			timerModeRegister <= RST_BYTE;
			tr0Q              <= 1'b0;
			tr1Q              <= 1'b0;
			tr2Q              <= 1'b0;
			ct2Q              <= 1'b0;
			cpRlQ             <= 1'b0;
			exenQ             <= 1'b0;
			downCountEnableQ  <= 1'b0;
			sixTModeQ         <= 1'b0;
		end else begin
			if (wrHit(OFS_TMODE)) begin
				timerModeRegister <= wByte;
			end
			if (wrHit(OFS_TCTRL)) begin
				tr0Q <= wByte[TC_TR0];
				tr1Q <= wByte[TC_TR1];
			end
			if (wrHit(OFS_T2CTRL)) begin
				tr2Q  <= wByte[T2_TR];
				ct2Q  <= wByte[T2_CT];
				cpRlQ <= wByte[T2_CPRL];
				exenQ <= wByte[T2_EXEN];
			end
			if (wrHit(OFS_T2MODE)) begin
				downCountEnableQ <= wByte[T2M_DOWN_COUNT_ENABLE];
			end
			if (wrHit(OFS_CFG)) begin
				sixTModeQ <= wByte[CFG_SIXT];
			end
		end
	end

	// ------------------------------------------------------------
	// timers 0 and 1
	// ------------------------------------------------------------
	logic [7:0]  tl0Q;
	logic [7:0]  th0Q;
	logic [7:0]  tl1Q;
	logic [7:0]  th1Q;
	logic [1:0]  mode0;
	logic [1:0]  mode1;
	logic [16:0] step0;
	logic [16:0] step1;
	logic        t0Split;
	logic        run0;
	logic        run1;
	logic        hiRun0;
	logic        set0;
	logic        set1;

	// returns {overflow, high, low} after one count in the given mode
	function automatic logic [16:0] stepCount(
		input logic [1:0] mode,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		logic [12:0] c13;
		logic [15:0] c16;
		c13 = {hi, lo[4:0]} + 13'h0001;
		c16 = {hi, lo} + 16'h0001;
		unique case (mode)
			MODE_13:    return {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
			MODE_16:    return {&{hi, lo}, c16};
			MODE_RLD:   return {&lo, hi, (&lo) ? hi : c16[7:0]};
			MODE_SPLIT: return {&lo, hi, c16[7:0]};
		endcase
	endfunction

	assign mode0   = {timerModeRegister[TM_M1], timerModeRegister[TM_M0]};
	assign mode1   = {timerModeRegister[TM_T1 + TM_M1], timerModeRegister[TM_T1 + TM_M0]};
	assign t0Split = (mode0 == MODE_SPLIT);
	assign step0   = stepCount(mode0, th0Q, tl0Q);
	assign step1   = stepCount(mode1, th1Q, tl1Q);

	always_comb begin
		run0 = mcBus.mcUpdate & tr0Q
			& (~timerModeRegister[TM_GATE] | externalInterruptPinZero)
			& (~timerModeRegister[TM_CT] | falls[EDGE_T0]);
		run1 = mcBus.mcUpdate & (mode1 != MODE_SPLIT)
			& (t0Split | tr1Q)
			& (~timerModeRegister[TM_T1 + TM_GATE] | externalInterruptPinOne)
			& (~timerModeRegister[TM_T1 + TM_CT] | falls[EDGE_T1]);
		hiRun0 = mcBus.mcUpdate & t0Split & tr1Q;
		set0   = run0 & step0[16];
		set1   = t0Split ? (hiRun0 & (&th0Q)) : (run1 & step1[16]);
	end

	// software writes win over a count in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			tl0Q <= RST_BYTE;
			th0Q <= RST_BYTE;
		end else begin
			if (wrHit(OFS_TL0)) begin
				tl0Q <= wByte;
			end else if (run0) begin
				tl0Q <= step0[7:0];
			end
			if (wrHit(OFS_TH0)) begin
				th0Q <= wByte;
			end else if (hiRun0) begin
				th0Q <= th0Q + 8'h01;
			end else if (run0) begin
				th0Q <= step0[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tl1Q <= RST_BYTE;
			th1Q <= RST_BYTE;
		end else begin
			if (wrHit(OFS_TL1)) begin
				tl1Q <= wByte;
			end else if (run1) begin
				tl1Q <= step1[7:0];
			end
			if (wrHit(OFS_TH1)) begin
				th1Q <= wByte;
			end else if (run1) begin
				th1Q <= step1[15:8];
			end
		end
	end

	// a hardware set always beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			timerZeroOverflowFlag <= 1'b0;
			timerOneOverflowFlag  <= 1'b0;
		end else begin
			timerZeroOverflowFlag <= set0 | (wrHit(OFS_TCTRL) ? wByte[TC_TF0]
				: (timerZeroOverflowFlag & ~vectorAckZero));
			timerOneOverflowFlag  <= set1 | (wrHit(OFS_TCTRL) ? wByte[TC_TF1]
				: (timerOneOverflowFlag & ~vectorAckOne));
		end
	end

	// ------------------------------------------------------------
	// timer 2
	// ------------------------------------------------------------
	logic [7:0]  tl2Q;
	logic [7:0]  th2Q;
	logic [7:0]  capLoQ;
	logic [7:0]  capHiQ;
	logic [15:0] next2;
	logic        run2;
	logic        ovf2;
	logic        trig2;

	// up/down counting is not built: a set down enable counts up as well
	assign next2 = {th2Q, tl2Q} + 16'h0001;
	assign run2  = mcBus.mcUpdate & tr2Q & (~ct2Q | falls[EDGE_T2]);
	assign ovf2  = run2 & (&{th2Q, tl2Q});
	assign trig2 = mcBus.mcUpdate & exenQ & falls[EDGE_TRIG];

	always_ff @(posedge clk) begin
		if (srst) begin
			tl2Q <= RST_BYTE;
			th2Q <= RST_BYTE;
		end else if (wrHit(OFS_TL2) || wrHit(OFS_TH2)) begin
			if (wrHit(OFS_TL2)) begin
				tl2Q <= wByte;
			end else begin
				th2Q <= wByte;
			end
		end else if (~cpRlQ && (ovf2 || trig2)) begin
			tl2Q <= capLoQ;
			th2Q <= capHiQ;
		end else if (run2) begin
			tl2Q <= next2[7:0];
			th2Q <= next2[15:8];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			capLoQ <= RST_BYTE;
			capHiQ <= RST_BYTE;
		end else if (cpRlQ && trig2) begin
			capLoQ <= tl2Q;
			capHiQ <= th2Q;
		end else begin
			if (wrHit(OFS_CAPL)) begin
				capLoQ <= wByte;
			end
			if (wrHit(OFS_CAPH)) begin
				capHiQ <= wByte;
			end
		end
	end

	// no vector clear here: only a software write drops these flags
	always_ff @(posedge clk) begin
		if (srst) begin
			timerTwoOverflowFlag <= 1'b0;
			externalTriggerFlag  <= 1'b0;
		end else begin
			timerTwoOverflowFlag <= ovf2 | (wrHit(OFS_T2CTRL) ? wByte[T2_TF]
				: timerTwoOverflowFlag);
			externalTriggerFlag  <= trig2 | (wrHit(OFS_T2CTRL) ? wByte[T2_EXF]
				: externalTriggerFlag);
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		rdByte = RST_BYTE;
		unique case (addrQ)
			OFS_TMODE:  rdByte = timerModeRegister;
			OFS_TCTRL: begin
				rdByte[TC_TF1] = timerOneOverflowFlag;
				rdByte[TC_TR1] = tr1Q;
				rdByte[TC_TF0] = timerZeroOverflowFlag;
				rdByte[TC_TR0] = tr0Q;
			end
			OFS_TL0:    rdByte = tl0Q;
			OFS_TH0:    rdByte = th0Q;
			OFS_TL1:    rdByte = tl1Q;
			OFS_TH1:    rdByte = th1Q;
			OFS_T2CTRL: begin
				rdByte[T2_TF]   = timerTwoOverflowFlag;
				rdByte[T2_EXF]  = externalTriggerFlag;
				rdByte[T2_EXEN] = exenQ;
				rdByte[T2_TR]   = tr2Q;
				rdByte[T2_CT]   = ct2Q;
				rdByte[T2_CPRL] = cpRlQ;
			end
			OFS_T2MODE: rdByte[T2M_DOWN_COUNT_ENABLE] = downCountEnableQ;
			OFS_CAPL:   rdByte = capLoQ;
			OFS_CAPH:   rdByte = capHiQ;
			OFS_TL2:    rdByte = tl2Q;
			OFS_TH2:    rdByte = th2Q;
			OFS_CFG:    rdByte[CFG_SIXT] = sixTModeQ;
			default:    rdByte = RST_BYTE;
		endcase
	end

endmodule

`default_nettype wire

/* File: test/ttcu_far_model.sv */
// far side: count, trigger, gate pins and core vector acks
// assumes pins sampled once per machine cycle of up to 12 clocks
`timescale 1ns/10ps
`default_nettype none

module ttcu_far_model (
	input  wire logic       clk,   // system clock
	output logic      [3:0] pins,  // count pins 0..2, trigger pin
	output logic      [1:0] gate,  // gate pins zero and one
	output logic      [1:0] ack    // vector acknowledges
);
	initial begin
		pins = 4'hF;
		gate = 2'h0;
		ack  = 2'h0;
	end

	// ----------
	// pin stimulus
	// ----------
	// levels outlast a 12-clock machine cycle
	task automatic pulse(input int i, input int n);
		repeat (n) begin
			@(posedge clk);
			pins[i] <= 1'b0;
			repeat (15) @(posedge clk);
			pins[i] <= 1'b1;
			repeat (14) @(posedge clk);
		end
	endtask

	task automatic setg(input int i, input logic v);
		@(posedge clk);
		gate[i] <= v;
	endtask

	// core vectors to a timer routine
	task automatic vec(input int i);
		@(posedge clk);
		ack[i] <= 1'b1;
		@(posedge clk);
		ack[i] <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* File: test/ttcu_monitor.sv */
// checker on the unit's ports: bus and flag timing
// assumes 12-clock machine cycles until short cycles are chosen
`timescale 1ns/10ps
`default_nettype none

module ttcu_monitor
	import ttcu_pkg::*;
(
	input wire logic        clk,                    // system clock
	input wire logic        srst,                   // synchronous reset
	input wire logic        hsel,                   // slave select
	input wire logic [31:0] haddr,                  // byte address
	input wire logic [1:0]  htrans,                 // transfer type
	input wire logic        hwrite,                 // write when high
	input wire logic [31:0] hwdata,                 // write data
	input wire logic        hready,                 // bus ready
	input wire logic        hreadyout,              // slave ready
	input wire logic [31:0] hrdata,                 // read data
	input wire logic        hresp,                  // response
	input wire logic        vectorAckZero,          // vector to timer 0
	input wire logic        vectorAckOne,           // vector to timer 1
	input wire logic        timerZeroOverflowFlag,  // timer 0 request
	input wire logic        timerOneOverflowFlag,   // timer 1 request
	input wire logic        timerTwoOverflowFlag,   // timer 2 request
	input wire logic        externalTriggerFlag     // trigger request
);
	logic       take;
	logic       rdPh;
	logic       wrPh;
	logic       cfgPh;
	logic       sixSeen;
	logic [3:0] ph;
	logic [3:0] fl;

	assign fl = {externalTriggerFlag, timerTwoOverflowFlag, timerOneOverflowFlag,
		timerZeroOverflowFlag};

	assign take = hsel & hready & htrans[1];

	// phase model holds for long cycles only
	always_ff @(posedge clk) begin
		if (srst) begin
			rdPh    <= 1'b0;
			wrPh    <= 1'b0;
			cfgPh   <= 1'b0;
			sixSeen <= 1'b0;
			ph      <= 4'h0;
		end else begin
			rdPh    <= take & ~hwrite;
			wrPh    <= take & hwrite;
			cfgPh   <= take & hwrite & (haddr[7:0] == OFS_CFG);
			sixSeen <= sixSeen | (cfgPh & hwdata[0]);
			ph      <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_take(logic w);
		hsel && hready && htrans[1] && (hwrite == w);
	endsequence
	sequence s_rdWait;
		!hreadyout ##1 hreadyout;
	endsequence

	property p_okay;
		hresp == RESP_OKAY;
	endproperty
	property p_read_wait;
		s_take(1'b0) |=> s_rdWait;
	endproperty
	property p_write_zero;
		s_take(1'b1) |=> hreadyout;
	endproperty
	property p_rdata_upper;
		hrdata[31:8] == 24'h0;
	endproperty
	property p_rdata_hold;
		!$past(rdPh) |-> $stable(hrdata);
	endproperty
	property p_tf0_clear;
		$fell(timerZeroOverflowFlag) |-> $past(vectorAckZero) || $past(wrPh);
	endproperty
	property p_tf1_clear;
		$fell(timerOneOverflowFlag) |-> $past(vectorAckOne) || $past(wrPh);
	endproperty
	property p_t2_clear;
		$fell(timerTwoOverflowFlag) || $fell(externalTriggerFlag) |-> $past(wrPh);
	endproperty
	property p_flag_phase;
		(|(fl & ~$past(fl))) && !$past(wrPh) && !sixSeen |-> ph == 4'h3;
	endproperty

	a_okay:        assert property (p_okay) else $error("not okay");
	a_read_wait:   assert property (p_read_wait) else $error("read wait");
	a_write_zero:  assert property (p_write_zero) else $error("write wait");
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper bits");
	a_rdata_hold:  assert property (p_rdata_hold) else $error("rdata moved");
	a_tf0_clear:   assert property (p_tf0_clear) else $error("tf0 lost");
	a_tf1_clear:   assert property (p_tf1_clear) else $error("tf1 lost");
	a_t2_clear:    assert property (p_t2_clear) else $error("t2 flag lost");
	a_flag_phase:  assert property (p_flag_phase) else $error("off phase");
endmodule

bind ttcu_top ttcu_monitor mon (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .vectorAckZero(vectorAckZero),
	.vectorAckOne(vectorAckOne), .timerZeroOverflowFlag(timerZeroOverflowFlag),
	.timerOneOverflowFlag(timerOneOverflowFlag), .timerTwoOverflowFlag(timerTwoOverflowFlag),
	.externalTriggerFlag(externalTriggerFlag));

`default_nettype wire

/* File: test/ttcu_top_tb.sv */
// self-checking bench: bus tasks, far-side model, integer expectations
// assumes 125 MHz clk; slave hreadyout is the bus hready
`timescale 1ns/10ps
`default_nettype none

module ttcu_top_tb;
	import ttcu_pkg::*;
	logic        clk;
	logic        srst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic [3:0]  pins;
	logic [1:0]  gate;
	logic [1:0]  ack;
	logic [3:0]  fl;
	logic [31:0] r;
	int          error_cnt;
	int          check_count;
	int          cyc;
	int          n;

	ttcu_far_model pm (.clk(clk), .pins(pins), .gate(gate), .ack(ack));

	ttcu_top DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
		.countPinZero(pins[0]), .countPinOne(pins[1]), .countPinTwo(pins[2]),
		.triggerPin(pins[3]), .externalInterruptPinZero(gate[0]),
		.externalInterruptPinOne(gate[1]), .vectorAckZero(ack[0]), .vectorAckOne(ack[1]),
		.timerZeroOverflowFlag(fl[0]), .timerOneOverflowFlag(fl[1]),
		.timerTwoOverflowFlag(fl[2]), .externalTriggerFlag(fl[3]));

	// ----------
	// helpers
	// ----------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// request held until hready is seen high at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, {24'h0, e}, r);
	endtask

	task automatic waitf(input int i, input int lim);
		n = 0;
		while (fl[i] !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	// timer 0 from a random start near overflow
	task automatic t0run(input logic [1:0] m, input int mc);
		logic [7:0] tl;
		logic [7:0] th;
		int         need;
		tl = 8'hF8 | 8'($urandom_range(7));
		th = (m == MODE_RLD) ? 8'hFE : 8'hFF;
		need = (m == MODE_13) ? 32 - int'(tl[4:0]) : 256 - int'(tl);
		wr(OFS_TL0, tl);
		wr(OFS_TH0, th);
		wr(OFS_TMODE, {6'h0, m});
		wr(OFS_TCTRL, 8'h10);
		waitf(0, need * mc + 4);
		chk("ovf cycles", 1'b1, n >= (need - 1) * mc && n <= need * mc + 3);
		wr(OFS_TCTRL, 8'h20);
		rdc("low byte", OFS_TL0, (m == MODE_13) ? (tl & 8'hE0) : (m == MODE_RLD) ? th : 8'h00);
		rdc("high byte", OFS_TH0, (m == MODE_RLD) ? th : 8'h00);
		pm.vec(0);
		@(posedge clk);
		chk("vector clear", 1'b0, fl[0]);
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ----------
	// main sequence
	// ----------
	initial begin
		srst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = SIZE_WORD;
		hwdata = 32'h0;
		error_cnt = 0;
		check_count = 0;
		cyc = 0;
		void'($urandom(18));
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a <= 8'h34; a += 4)
			rdc("reset value", 8'(a), 8'h00);
		wr(8'h34, 8'hA5);
		wr(8'h09, 8'h5A);
		wr(OFS_TCTRL, 8'h0F);
		rdc("unmapped", 8'h34, 8'h00);
		rdc("unaligned", OFS_TL0, 8'h00);
		rdc("tctrl low", OFS_TCTRL, 8'h00);
		$display("test registers done");
		wr(OFS_TMODE, 8'h09);
		wr(OFS_TCTRL, 8'h10);
		repeat (60) @(posedge clk);
		rdc("gated count", OFS_TL0, 8'h00);
		pm.setg(0, 1'b1);
		repeat (60) @(posedge clk);
		wr(OFS_TCTRL, 8'h00);
		bus(1'b0, OFS_TL0, 8'h00);
		chk("ungated count", 1'b1, r >= 32'h4 && r <= 32'h7);
		$display("test gate done");
		for (int m = 0; m < 3; m++)
			t0run(2'(m), MC_LONG);
		$display("test t0 modes done");
		wr(OFS_TL1, 8'hFD);
		wr(OFS_TH1, 8'hFD);
		wr(OFS_TMODE, 8'h60);
		wr(OFS_TCTRL, 8'h40);
		pm.pulse(1, 2);
		rdc("edges", OFS_TL1, 8'hFF);
		chk("early ovf", 1'b0, fl[1]);
		pm.pulse(1, 1);
		waitf(1, 40);
		chk("counter ovf", 1'b1, fl[1]);
		rdc("reload", OFS_TL1, 8'hFD);
		$display("test counter done");
		wr(OFS_TL1, 8'h55);
		wr(OFS_TL0, 8'hFF);
		wr(OFS_TH0, 8'hFE);
		wr(OFS_TMODE, 8'h37);
		wr(OFS_TCTRL, 8'h50);
		pm.pulse(0, 1);
		chk("split low flag", 1'b1, fl[0]);
		chk("split high flag", 1'b1, fl[1]);
		rdc("t1 frozen", OFS_TL1, 8'h55);
		wr(OFS_TCTRL, 8'h00);
		wr(OFS_TMODE, 8'h27);
		repeat (36) @(posedge clk);
		wr(OFS_TMODE, 8'h37);
		bus(1'b0, OFS_TL1, 8'h00);
		chk("t1 no run", 1'b1, r >= 32'h56 && r <= 32'h5A);
		$display("test split mode done");
		wr(OFS_TL2, 8'hFE);
		wr(OFS_TH2, 8'hFF);
		wr(OFS_T2CTRL, 8'h0D);
		waitf(2, 40);
		chk("t2 rollover", 1'b1, fl[2]);
		pm.pulse(3, 1);
		chk("cap flag", 1'b1, fl[3]);
		rdc("cap high", OFS_CAPH, 8'h00);
		repeat (24) @(posedge clk);
		chk("t2 flags kept", 2'h3, fl[3:2]);
		wr(OFS_T2CTRL, 8'h00);
		@(posedge clk);
		chk("t2 flags clear", 2'h0, fl[3:2]);
		wr(OFS_CAPL, 8'h80);
		wr(OFS_CAPH, 8'h12);
		wr(OFS_TL2, 8'hFF);
		wr(OFS_TH2, 8'hFF);
		wr(OFS_T2CTRL, 8'h04);
		waitf(2, 30);
		chk("reload ovf", 1'b1, fl[2]);
		rdc("reloaded high", OFS_TH2, 8'h12);
		wr(OFS_T2CTRL, 8'h0E);
		pm.pulse(3, 1);
		rdc("trigger reload", OFS_TL2, 8'h80);
		chk("trigger flag", 1'b1, fl[3]);
		pm.pulse(2, 3);
		rdc("pin counted", OFS_TL2, 8'h83);
		$display("test t2 done");
		wr(OFS_CFG, 8'h01);
		t0run(MODE_RLD, MC_SHORT);
		$display("test short cycle done");
		wrap_up();
	end
endmodule

`default_nettype wire
